// ==== bench/anss_mgr_model.sv ====
// Station manager model that drives the register port of the bank
`timescale 1ns/1ps
module anss_mgr_model
(
	input  wire logic        clk_sys,
	input  wire logic [15:0] reg_rdata_q,
	input  wire logic        reg_rvalid_q,
	output logic      [15:0] reg_addr = 16'h0000,
	output logic             reg_wr = 1'b0,
	output logic             reg_rd = 1'b0,
	output logic      [15:0] reg_wdata = 16'h0000
);
	// One-cycle strobe; released data shows its inverse so stale values never look valid
	task automatic acc(input logic w, input logic [15:0] a, d, output logic [15:0] q);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = ~d;
		q = (w || reg_rvalid_q === 1'b1) ? reg_rdata_q : 16'hxxxx;
	endtask
	// Shadow read: select with write enable clear, then read the slot
	task automatic shd_rd(input logic [4:0] s, output logic [15:0] q);
		acc(1'b1, 16'hfffc, {1'b0, s, 10'h000}, q);
		acc(1'b0, 16'hfffc, 16'h0000, q);
	endtask
	// Read-modify-write of the spare shadow keeps the reserved bits
	task automatic rmw(input logic [2:0] r, input logic e);
		logic [15:0] q;
		shd_rd(5'h04, q);
		acc(1'b1, 16'hfffc, {1'b1, 5'h04, q[9:5], r, e, q[0]}, q);
	endtask
endmodule

// ==== bench/anss_regs_checker.sv ====
// Assertion checker for the status and shadow register bank
`timescale 1ns/1ps
module anss_regs_checker
(
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        clk_en,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata_q,
	input wire logic        an_enable,
	input wire logic        an_complete,
	input wire logic [2:0]  manual_speed_duplex,
	input wire logic        evt_ack_detect,
	input wire logic [2:0]  retry_limit_q,
	input wire logic [3:0]  retry_attempts_q
);
	// Status read taken on this edge
	wire st = reg_rd && clk_en && reg_addr == 16'hfff9;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_done_bit: assert property (st |=> reg_rdata_q[15] == $past(an_complete))
		else $error("done bit wrong");
	a_speed_wait: assert property (st && an_enable && !an_complete |=> reg_rdata_q[10:8] == 3'h0)
		else $error("early speed code");
	a_manual_mode: assert property (st && !an_enable && manual_speed_duplex > 3'h2
		|=> reg_rdata_q[10:8] == $past(manual_speed_duplex)) else $error("manual mode wrong");
	a_pause_mask: assert property (st && !an_complete |=> reg_rdata_q[1:0] == 2'h0)
		else $error("pause not masked");
	a_ack_latch: assert property (evt_ack_detect && clk_en ##1 !st ##1 st |=> reg_rdata_q[13])
		else $error("ack event lost");
	a_ack_clear: assert property (st && !evt_ack_detect ##1 !st && !evt_ack_detect
		##1 st |=> !reg_rdata_q[13]) else $error("ack flag not cleared");
	a_retry_count: assert property (retry_attempts_q == {1'b0, retry_limit_q} + 4'h2)
		else $error("attempt count wrong");
	a_retry_write: assert property (reg_wr && clk_en && reg_addr == 16'hfffc
		&& reg_wdata[15:10] == 6'h24 ##1 clk_en |=> retry_limit_q == $past(reg_wdata[4:2], 2))
		else $error("retry field not written");
endmodule

bind anss_regs anss_regs_checker i_anss_regs_checker
(
	.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
	.an_enable(an_enable), .an_complete(an_complete),
	.manual_speed_duplex(manual_speed_duplex), .evt_ack_detect(evt_ack_detect),
	.retry_limit_q(retry_limit_q), .retry_attempts_q(retry_attempts_q)
);

// ==== bench/tb_top.sv ====
// Self-checking bench for the status and shadow register bank
`timescale 1ns/1ps
module tb_top;
	logic        clk_sys = 1'b0, resetn = 1'b0, clk_en = 1'b1, an_enable = 1'b1;
	logic        an_complete = 1'b0, energy_detect = 1'b0, normal_interrupt = 1'b0;
	logic [2:0]  an_resolved_code = 3'h5, manual_speed_duplex = 3'h0;
	logic [5:0]  evts = 6'h00, lvls = 6'h00;
	wire  [15:0] reg_addr, reg_wdata, reg_rdata_q;
	wire         reg_wr, reg_rd, reg_rvalid_q, interrupt_output_q;
	wire  [2:0]  retry_limit_q;
	wire  [3:0]  retry_attempts_q;
	logic [15:0] q;
	int          fails = 0, samples_checked = 0, cyc = 0, i;

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;
	// Events and partner levels travel as bit vectors to keep the hookup short
	anss_regs i_anss_regs
	(
		.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
		.reg_rvalid_q(reg_rvalid_q), .an_enable(an_enable), .an_complete(an_complete),
		.an_resolved_code(an_resolved_code), .manual_speed_duplex(manual_speed_duplex),
		.evt_link_good_check(evts[5]), .evt_ack_detect(evts[4]), .evt_ability_detect(evts[3]),
		.evt_next_page_wait(evts[2]), .evt_parallel_fault(evts[1]), .evt_page_received(evts[0]),
		.lp_remote_fault(lvls[5]), .lp_an_able(lvls[4]), .lp_next_page(lvls[3]),
		.link_good(lvls[2]), .pause_rx_ok(lvls[1]), .pause_tx_ok(lvls[0]),
		.energy_detect(energy_detect), .normal_interrupt(normal_interrupt),
		.interrupt_output_q(interrupt_output_q), .retry_limit_q(retry_limit_q),
		.retry_attempts_q(retry_attempts_q)
	);
	anss_mgr_model i_anss_mgr_model
	(
		.clk_sys(clk_sys), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata)
	);
	// Compare, report and count
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e)
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		fails += int'(g !== e);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Expected status word; reserved speed codes read as none
	function automatic logic [15:0] st_exp(input logic [5:0] e);
		logic [2:0] s;
		s = an_enable ? (an_complete ? an_resolved_code : 3'h0) : manual_speed_duplex;
		s = (s == 3'h1 || s == 3'h2) ? 3'h0 : s;
		return {an_complete, e[5:2], s, e[1], lvls[5], e[0], lvls[4:2],
			lvls[1:0] & {2{an_complete}}};
	endfunction
	task automatic rs(input logic [15:0] e);
		i_anss_mgr_model.acc(1'b0, 16'hfff9, 16'h0000, q);
		chk(q, e);
	endtask
	task automatic ss(input logic [4:0] s, input logic [15:0] e);
		i_anss_mgr_model.shd_rd(s, q);
		chk(q, e);
	endtask
	task automatic wf(input logic [15:0] d);
		i_anss_mgr_model.acc(1'b1, 16'hfffc, d, q);
	endtask
	task automatic pulse(input logic [5:0] e);
		@(negedge clk_sys);
		evts = e;
		@(negedge clk_sys);
		evts = 6'h00;
	endtask
	// Hang guard, far above the under two hundred cycles the sequence needs
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			wrap_up;
		end
	end
	initial
	begin
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		resetn = 1'b1;
		// Reset values, then all latched events read once and cleared
		rs(16'h0000);
		chk(16'(retry_attempts_q), 16'h0002);
		ss(5'h04, 16'h1000);
		lvls = 6'h3f;
		rs(st_exp(6'h00));
		pulse(6'h3f);
		rs(st_exp(6'h3f));
		rs(st_exp(6'h00));
		// An event in the read cycle survives the clear
		fork
			rs(st_exp(6'h00));
			pulse(6'h15);
		join
		rs(st_exp(6'h15));
		// Two more patterns give every flag its own signature
		pulse(6'h0f);
		rs(st_exp(6'h0f));
		pulse(6'h33);
		rs(st_exp(6'h33));
		// Every speed code, negotiated and then manual
		an_complete = 1'b1;
		for (i = 0; i < 16; i++)
		begin
			an_enable = (i < 8);
			an_resolved_code = 3'(i);
			manual_speed_duplex = 3'(i);
			rs(st_exp(6'h00));
		end
		// Partner levels in three patterns so every bit has its own signature
		for (i = 0; i < 3; i++)
		begin
			lvls = (i == 0) ? 6'h0f : ((i == 1) ? 6'h33 : 6'h55);
			rs(st_exp(6'h00));
		end
		lvls = 6'h00;
		rs(st_exp(6'h00));
		// Retry codes by read-modify-write over set reserved bits
		wf(16'h93e1);
		for (i = 0; i < 8; i++)
		begin
			i_anss_mgr_model.rmw(3'(i), 1'b0);
			repeat (2) @(negedge clk_sys);
			chk(16'(retry_attempts_q), 16'(i + 2));
			chk(16'(retry_limit_q), 16'(i));
		end
		ss(5'h04, 16'h13fd);
		// Power-down shadow and a frozen clock leave the spare data alone
		ss(5'h0a, 16'h2800);
		wf(16'habff);
		clk_en = 1'b0;
		wf(16'h9000);
		clk_en = 1'b1;
		ss(5'h04, 16'h13fd);
		// Interrupt source follows the route bit
		normal_interrupt = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk(16'(interrupt_output_q), 16'h0001);
		i_anss_mgr_model.rmw(3'h7, 1'b1);
		repeat (5) @(negedge clk_sys);
		chk(16'(interrupt_output_q), 16'h0000);
		energy_detect = 1'b1;
		normal_interrupt = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk(16'(interrupt_output_q), 16'h0001);
		wrap_up;
	end
endmodule

// ==== hdl/anss_map.vh ====
// Register offsets, field positions, codes and reset values of the status and shadow bank
`ifndef ANSS_MAP_VH
`define ANSS_MAP_VH

// Register addresses in device 7
`define ANSS_ADDR_STATUS      16'hfff9
`define ANSS_ADDR_SHADOW      16'hfffc

// Status summary field positions
`define ANSS_ST_COMPLETE      15
`define ANSS_ST_LGC           14
`define ANSS_ST_ACKD          13
`define ANSS_ST_ABD           12
`define ANSS_ST_NPW           11
`define ANSS_ST_SPD_HI        10
`define ANSS_ST_SPD_LO        8
`define ANSS_ST_PDF           7
`define ANSS_ST_RFLT          6
`define ANSS_ST_PGRX          5
`define ANSS_ST_LPAN          4
`define ANSS_ST_LPNP          3
`define ANSS_ST_LINK          2
`define ANSS_ST_PAUSE_RX      1
`define ANSS_ST_PAUSE_TX      0

// Resolved speed and duplex codes
`define ANSS_SPD_1000_FD      3'h7
`define ANSS_SPD_1000_HD      3'h6
`define ANSS_SPD_100TX_FD     3'h5
`define ANSS_SPD_100T4        3'h4
`define ANSS_SPD_100TX_HD     3'h3
`define ANSS_SPD_RSVD2        3'h2
`define ANSS_SPD_RSVD1        3'h1
`define ANSS_SPD_NONE         3'h0

// Shadowed register slot fields
`define ANSS_SH_WEN           15
`define ANSS_SH_SEL_HI        14
`define ANSS_SH_SEL_LO        10
`define ANSS_SH_DATA_HI       9
`define ANSS_SH_DATA_LO       0
`define ANSS_SHD_SPARE        5'h04
`define ANSS_SHD_APD          5'h0a

// Spare control fields
`define ANSS_SP_RETRY_HI      4
`define ANSS_SP_RETRY_LO      2
`define ANSS_SP_ED_ROUTE      1
`define ANSS_RETRY_BASE       4'h2

// Reset values
`define ANSS_RST_SEL          5'h04
`define ANSS_RST_SPARE        10'h000
`define ANSS_RST_RETRY        3'h0
`define ANSS_RST_WORD         16'h0000

`endif

// ==== hdl/anss_regs.v ====
// Negotiation status summary and shadowed spare-control register logic
//
// What this block does
// - Bit 15 high once negotiation has finished
// - Bit 14 latches link-good-check entry, clears on read
// - Bit 13 latches acknowledge-detect entry, clears on read
// - Bit 12 latches ability-detect entry, clears on read
// - Bit 11 latches next-page-wait entry, clears on read
// - Speed/duplex field zero until completion is flagged
// - Negotiation disabled: field shows manually selected mode
// - Speed/duplex codes, reserved codes, zero means none
// - Bit 7 latches parallel detection fault until read
// - Bit 6 shows partner remote fault
// - Bit 5 latches new partner page until read
// - Bit 4 shows partner negotiation ability
// - Bit 3 shows partner next-page intent
// - Bit 2 shows link good
// - Bits 1:0 pause resolution, valid once complete
// - Write bits 14:10 select, bit 15 enables data
// - Select with bit 15 clear, next read returns it
// - Selector 00100 spare control, 01010 power-down
// - Retry code 000..111 means two..nine attempts
// - Spare bit 1 routes energy detect to interrupt
`timescale 1ns/1ps
`include "anss_map.vh"

module anss_regs
(
	clk_sys,
	resetn,
	clk_en,
	reg_addr,
	reg_wr,
	reg_rd,
	reg_wdata,
	reg_rdata_q,
	reg_rvalid_q,
	an_enable,
	an_complete,
	an_resolved_code,
	manual_speed_duplex,
	evt_link_good_check,
	evt_ack_detect,
	evt_ability_detect,
	evt_next_page_wait,
	evt_parallel_fault,
	evt_page_received,
	lp_remote_fault,
	lp_an_able,
	lp_next_page,
	link_good,
	pause_rx_ok,
	pause_tx_ok,
	energy_detect,
	normal_interrupt,
	interrupt_output_q,
	retry_limit_q,
	retry_attempts_q
);
	input  wire        clk_sys;
	input  wire        resetn;
	input  wire        clk_en;
	input  wire [15:0] reg_addr;
	input  wire        reg_wr;
	input  wire        reg_rd;
	input  wire [15:0] reg_wdata;
	output reg  [15:0] reg_rdata_q;
	output reg         reg_rvalid_q;
	input  wire        an_enable;
	input  wire        an_complete;
	input  wire [2:0]  an_resolved_code;
	input  wire [2:0]  manual_speed_duplex;
	input  wire        evt_link_good_check;
	input  wire        evt_ack_detect;
	input  wire        evt_ability_detect;
	input  wire        evt_next_page_wait;
	input  wire        evt_parallel_fault;
	input  wire        evt_page_received;
	input  wire        lp_remote_fault;
	input  wire        lp_an_able;
	input  wire        lp_next_page;
	input  wire        link_good;
	input  wire        pause_rx_ok;
	input  wire        pause_tx_ok;
	input  wire        energy_detect;
	input  wire        normal_interrupt;
	output reg         interrupt_output_q;
	output reg  [2:0]  retry_limit_q;
	output reg  [3:0]  retry_attempts_q;

	// Sticky flag slots inside the helper bank
	localparam [2:0] FL_LGC  = 3'h0;
	localparam [2:0] FL_ACKD = 3'h1;
	localparam [2:0] FL_ABD  = 3'h2;
	localparam [2:0] FL_NPW  = 3'h3;
	localparam [2:0] FL_PDF  = 3'h4;
	localparam [2:0] FL_PGRX = 3'h5;
	localparam       NFLAGS  = 6;

	reg  [4:0]        shadow_sel_q;
	reg  [4:0]        shadow_sel_d;
	reg  [9:0]        spare_q;
	reg  [9:0]        spare_d;
	reg               ed_meta_q;
	reg               ed_sync_q;
	reg               int_out_d;
	reg  [15:0]       status_word;
	reg  [15:0]       shadow_word;
	reg  [15:0]       rdata_d;
	reg  [2:0]        speed_field;
	reg  [3:0]        attempts_d;
	wire [NFLAGS-1:0] evt_vec;
	wire [NFLAGS-1:0] flags;
	wire              hit_status;
	wire              hit_shadow;
	wire              status_read;
	wire              shadow_write;
	wire              sel_spare;
	wire              sel_apd;
	wire [4:0]        wr_sel;
	wire              wr_data_en;

	// Only the codes that name a real mode pass; reserved codes read as none
	function [2:0] anss_legal;
		input [2:0] code;
		begin
			case (code)
				`ANSS_SPD_1000_FD:  anss_legal = code;
				`ANSS_SPD_1000_HD:  anss_legal = code;
				`ANSS_SPD_100TX_FD: anss_legal = code;
				`ANSS_SPD_100T4:    anss_legal = code;
				`ANSS_SPD_100TX_HD: anss_legal = code;
				`ANSS_SPD_RSVD2:    anss_legal = `ANSS_SPD_NONE;
				`ANSS_SPD_RSVD1:    anss_legal = `ANSS_SPD_NONE;
				default:            anss_legal = `ANSS_SPD_NONE;
			endcase
		end
	endfunction

	// Address decode of the register port; writes to the status address
	// or to an unmapped one decode to nothing and are dropped
	assign hit_status   = (reg_addr == `ANSS_ADDR_STATUS);
	assign hit_shadow   = (reg_addr == `ANSS_ADDR_SHADOW);
	assign status_read  = reg_rd & hit_status;
	assign shadow_write = reg_wr & hit_shadow;

	// Fields of an incoming slot write
	assign wr_sel     = reg_wdata[`ANSS_SH_SEL_HI:`ANSS_SH_SEL_LO];
	assign wr_data_en = reg_wdata[`ANSS_SH_WEN];

	// Selector decode against the stored shadow code
	assign sel_spare = (shadow_sel_q == `ANSS_SHD_SPARE);
	assign sel_apd   = (shadow_sel_q == `ANSS_SHD_APD);

	// State-entry and event pulses from the negotiation logic, same clock, no sync
	assign evt_vec[FL_LGC]  = evt_link_good_check;
	assign evt_vec[FL_ACKD] = evt_ack_detect;
	assign evt_vec[FL_ABD]  = evt_ability_detect;
	assign evt_vec[FL_NPW]  = evt_next_page_wait;
	assign evt_vec[FL_PDF]  = evt_parallel_fault;
	assign evt_vec[FL_PGRX] = evt_page_received;

	// Clear-on-read latches; the read samples them in the same cycle as the clear
	anss_sticky
	#(
		.WIDTH   (NFLAGS)
	)
	u_sticky
	(
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.clk_en  (clk_en),
		.set_evt (evt_vec),
		.clr_rd  (status_read),
		.flags_q (flags)
	);

	// Resolved mode: manual selection wins when negotiation is turned off
	always @*
	begin
		speed_field = `ANSS_SPD_NONE;
		if (!an_enable)
			speed_field = anss_legal(manual_speed_duplex);
		else if (an_complete)
			speed_field = anss_legal(an_resolved_code);
		else
			speed_field = `ANSS_SPD_NONE;
	end

	// Status summary word as seen by a read
	always @*
	begin
		status_word = `ANSS_RST_WORD;
		status_word[`ANSS_ST_COMPLETE] = an_complete;
		status_word[`ANSS_ST_LGC]      = flags[FL_LGC];
		status_word[`ANSS_ST_ACKD]     = flags[FL_ACKD];
		status_word[`ANSS_ST_ABD]      = flags[FL_ABD];
		status_word[`ANSS_ST_NPW]      = flags[FL_NPW];
		status_word[`ANSS_ST_SPD_HI:`ANSS_ST_SPD_LO] = speed_field;
		status_word[`ANSS_ST_PDF]      = flags[FL_PDF];
		status_word[`ANSS_ST_RFLT]     = lp_remote_fault;
		status_word[`ANSS_ST_PGRX]     = flags[FL_PGRX];
		status_word[`ANSS_ST_LPAN]     = lp_an_able;
		status_word[`ANSS_ST_LPNP]     = lp_next_page;
		status_word[`ANSS_ST_LINK]     = link_good;
		// Pause results are masked until completion so stale values never show
		status_word[`ANSS_ST_PAUSE_RX] = an_complete & pause_rx_ok;
		status_word[`ANSS_ST_PAUSE_TX] = an_complete & pause_tx_ok;
	end

	// Shadow slot read word: stored selector plus spare data when the spare shadow is selected, zero data for any other slot
	always @*
	begin
		shadow_word = `ANSS_RST_WORD;
		shadow_word[`ANSS_SH_SEL_HI:`ANSS_SH_SEL_LO] = shadow_sel_q;
		if (sel_spare)
			shadow_word[`ANSS_SH_DATA_HI:`ANSS_SH_DATA_LO] = spare_q;
		else if (sel_apd)
			shadow_word[`ANSS_SH_DATA_HI:`ANSS_SH_DATA_LO] = 10'h000;
		else
			shadow_word[`ANSS_SH_DATA_HI:`ANSS_SH_DATA_LO] = 10'h000;
	end

	// Read data mux; an unmapped address answers zero
	always @*
	begin
		rdata_d = `ANSS_RST_WORD;
		if (hit_status)
			rdata_d = status_word;
		else if (hit_shadow)
			rdata_d = shadow_word;
		else
			rdata_d = `ANSS_RST_WORD;
	end

	// Every write to the slot moves the selector; data only moves with write enable
	always @*
	begin
		shadow_sel_d = shadow_sel_q;
		spare_d      = spare_q;
		if (shadow_write)
		begin
			shadow_sel_d = wr_sel;
			// Selector in the same word decides the target, not the old one
			if (wr_data_en && (wr_sel == `ANSS_SHD_SPARE))
				spare_d = reg_wdata[`ANSS_SH_DATA_HI:`ANSS_SH_DATA_LO];
		end
	end

	// Attempt count is code plus two, so 000 gives two and 111 gives nine
	always @*
	begin
		attempts_d = {1'b0, spare_q[`ANSS_SP_RETRY_HI:`ANSS_SP_RETRY_LO]} +
		             `ANSS_RETRY_BASE;
	end

	// Shadow storage
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			shadow_sel_q <= `ANSS_RST_SEL;
			spare_q      <= `ANSS_RST_SPARE;
		end
		else if (clk_en)
		begin
			shadow_sel_q <= shadow_sel_d;
			spare_q      <= spare_d;
		end
	end

	// Read answer is registered; it stands until the next read replaces it
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			reg_rdata_q  <= `ANSS_RST_WORD;
			reg_rvalid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			reg_rvalid_q <= reg_rd;
			if (reg_rd)
				reg_rdata_q <= rdata_d;
		end
	end

	// Energy detect comes from the analog front end, so it is synchronised first
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ed_meta_q <= 1'b0;
			ed_sync_q <= 1'b0;
		end
		else if (clk_en)
		begin
			ed_meta_q <= energy_detect;
			ed_sync_q <= ed_meta_q;
		end
	end

	// Interrupt pin source; the energy path lags by the two sync flops, so a
	// route change can show one stale sample taken from the other source
	always @*
	begin
		int_out_d = normal_interrupt;
		if (spare_q[`ANSS_SP_ED_ROUTE])
			int_out_d = ed_sync_q;
		else
			int_out_d = normal_interrupt;
	end

	// Interrupt pin flop, so the pin never shows a decode glitch
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			interrupt_output_q <= 1'b0;
		else if (clk_en)
			interrupt_output_q <= int_out_d;
	end

	// Retry limit and attempt count follow the spare shadow one cycle later
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			retry_limit_q    <= `ANSS_RST_RETRY;
			retry_attempts_q <= `ANSS_RETRY_BASE;
		end
		else if (clk_en)
		begin
			retry_limit_q    <= spare_q[`ANSS_SP_RETRY_HI:`ANSS_SP_RETRY_LO];
			retry_attempts_q <= attempts_d;
		end
	end

endmodule

// ==== hdl/anss_sticky.v ====
// Bank of clear-on-read event flags in which a new event beats the clear
`timescale 1ns/1ps

module anss_sticky
#(
	parameter WIDTH = 6
)
(
	clk_sys,
	resetn,
	clk_en,
	set_evt,
	clr_rd,
	flags_q
);
	input  wire             clk_sys;
	input  wire             resetn;
	input  wire             clk_en;
	input  wire [WIDTH-1:0] set_evt;
	input  wire             clr_rd;
	output reg  [WIDTH-1:0] flags_q;

	wire        [WIDTH-1:0] flags_d;

	genvar gi;

	// Next value per flag; the set term is ORed last so an event in the read cycle survives
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1)
		begin : g_flag
			assign flags_d[gi] = set_evt[gi] | (flags_q[gi] & ~clr_rd);
		end
	endgenerate

	// One register for the whole bank keeps a single driver per flag
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			flags_q <= {WIDTH{1'b0}};
		else if (clk_en)
			flags_q <= flags_d;
	end

endmodule
